// ==== design/sso_cfg.svh ====
// constants for the stereo serial output port: offsets, positions, reset values, counts
`ifndef SSO_CFG_SVH
`define SSO_CFG_SVH
`define SSO_OFS_LEFT 12'h000
`define SSO_OFS_RIGHT 12'h004
`define SSO_OFS_STATUS 12'h008
`define SSO_SAMPLE_RST 16'h0000
`define SSO_ST_BUSY 0
`define SSO_ST_OVERRUN 1
`define SSO_ST_STRAP_LSB 2
`define SSO_WORD_LAST 5'h0F
`define SSO_FIELD_LAST 5'h1F
`define SSO_CNT_RST 6'h3F
`define SSO_POS_LEFT_JUST 5'h00
`define SSO_POS_I2S 5'h01
`define SSO_POS_I2S_END 5'h10
`define SSO_POS_RIGHT_JUST 5'h10
`define SSO_POS_RIGHT_JUST_P1 5'h11
`define SSO_UPDATE_SLOT 6'h38
`define SSO_DIV_XMIT 2'h0
`define SSO_DIV_SAMPLE 2'h2
`endif

// ==== design/sso_pkg.sv ====
// types shared by the stereo serial output port
package sso_pkg;
  // static strap pins
  typedef struct packed {
    logic delay_n;
    logic justify;
    logic slave;
  } sso_strap_t;
  // one stereo sample
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } sso_pair_t;
  // slave start-up: wait channel clock low, then high
  typedef enum logic [1:0] {
    SSO_ARM_LOW = 2'b00,
    SSO_ARM_HIGH = 2'b01,
    SSO_RUN = 2'b11
  } sso_arm_t;
endpackage

// ==== design/sso_port.sv ====
// stereo serial output port with apb sample registers and link-side shifter
`timescale 1ns/100ps
`include "sso_cfg.svh"
module sso_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clock_in,
  input wire logic slave_select,
  input wire logic justify_select,
  input wire logic first_bit_delay_n,
  input wire logic edge_polarity_select,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  input wire logic channel_select_clock_in,
  output logic channel_select_clock_out,
  output logic channel_select_clock_oe_n,
  input wire logic word_clock_in,
  output logic word_clock_out,
  output logic word_clock_oe_n,
  output logic serial_data_out
);

  // ---- register side, ref_clk ----
  logic [15:0] left_word; // software left sample
  logic [15:0] right_word; // software right sample
  sso_pkg::sso_pair_t xfer_pair; // held stable while a hand-over is open
  logic req_tgl; // toggles once per committed pair
  logic ack_meta; // first stage of ack sync
  logic ack_s; // ack seen on ref side
  logic overrun; // sticky: commit refused while busy
  logic [2:0] strap_meta_r; // strap sync, stage one
  logic [2:0] strap_r; // strap sync, stage two
  logic setup_ph; // apb setup cycle
  logic access_ok; // apb access completing now
  logic mapped; // address hits a register
  logic busy; // hand-over still open
  logic ack_tgl; // returns the commit toggle, written on the link side

  assign setup_ph = psel & ~penable;
  assign access_ok = psel & penable & pready;
  assign busy = req_tgl ^ ack_s;
  assign mapped = (paddr == `SSO_OFS_LEFT) | (paddr == `SSO_OFS_RIGHT)
    | (paddr == `SSO_OFS_STATUS);

  // apb answer: ready in the first access cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
    end
  end

  // read data captured in setup, zero for unmapped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setup_ph && !pwrite)
    begin
      case (paddr)
        `SSO_OFS_LEFT: prdata <= {16'h0000, left_word};
        `SSO_OFS_RIGHT: prdata <= {16'h0000, right_word};
        `SSO_OFS_STATUS: prdata <= {27'h0000000, strap_r, overrun, busy};
        default: prdata <= 32'h00000000;
      endcase
    end
    else if (setup_ph)
      prdata <= 32'h00000000;
  end

  // sample registers; writing right commits the pair
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_word <= `SSO_SAMPLE_RST;
      right_word <= `SSO_SAMPLE_RST;
      xfer_pair <= '0;
      req_tgl <= 1'b0;
    end
    else if (access_ok && pwrite && paddr == `SSO_OFS_LEFT)
      left_word <= pwdata[15:0];
    else if (access_ok && pwrite && paddr == `SSO_OFS_RIGHT)
    begin
      right_word <= pwdata[15:0];
      // open a hand-over only when the last one closed
      if (!busy)
      begin
        xfer_pair <= {left_word, pwdata[15:0]};
        req_tgl <= ~req_tgl;
      end
    end
  end

  // overrun flag: set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      overrun <= 1'b0;
    else if (access_ok && pwrite && paddr == `SSO_OFS_RIGHT && busy)
      overrun <= 1'b1;
    else if (access_ok && pwrite && paddr == `SSO_OFS_STATUS && pwdata[`SSO_ST_OVERRUN])
      overrun <= 1'b0;
  end

  // ack and strap synchronisers into ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_meta <= 1'b0;
      ack_s <= 1'b0;
      strap_meta_r <= 3'h0;
      strap_r <= 3'h0;
    end
    else
    begin
      ack_meta <= ack_tgl;
      ack_s <= ack_meta;
      strap_meta_r <= {first_bit_delay_n, justify_select, slave_select};
      strap_r <= strap_meta_r;
    end
  end

  // ---- link side, master_clock_in ----
  logic [7:0] pin_meta; // pin sync, stage one
  logic [7:0] pin_s; // pin sync, stage two
  sso_pkg::sso_strap_t strap; // synced straps
  logic edge_sel; // synced edge polarity select
  logic bclk_s; // synced bit clock in
  logic lr_s; // synced channel clock in
  logic wclk_s; // synced word clock in
  logic req_s; // synced commit toggle
  logic bclk_prev; // previous synced bit clock
  logic [2:0] sync_fill; // fills with ones after reset
  logic sync_ok; // synced pins are settled
  logic [1:0] mdiv; // master clock divider, four per bit
  logic tx_ev; // transmitting edge this cycle
  logic smp_ev; // sampling edge this cycle
  logic [5:0] cnt; // bit index in frame, bit 5 set on right field
  logic [5:0] next_cnt; // bit index after this transmit edge
  logic lr_fld; // channel level of the current field
  sso_pkg::sso_arm_t arm; // start-up state
  logic active; // port running
  logic wc_mode; // word clock is an input
  logic wc_pend; // word clock seen high, msb due
  logic wc_done; // word already started in this field
  logic [4:0] start_pos; // msb slot for fixed modes
  logic start; // load a word at this transmit edge
  logic [15:0] load_word; // word for the field about to run
  logic [15:0] shreg; // remaining bits, msb aligned
  logic [4:0] bits_left; // bits still to send
  logic next_wclk; // word clock level for the next bit
  sso_pkg::sso_pair_t pend_pair; // pair received from ref side
  sso_pkg::sso_pair_t act_pair; // pair being shifted

  assign strap = sso_pkg::sso_strap_t'(pin_s[2:0]);
  assign edge_sel = pin_s[3];
  assign bclk_s = pin_s[4];
  assign lr_s = pin_s[5];
  assign wclk_s = pin_s[6];
  assign req_s = pin_s[7];
  assign active = (arm == sso_pkg::SSO_RUN);
  assign sync_ok = sync_fill[2];
  assign wc_mode = strap.slave & strap.justify & ~strap.delay_n;

  // two-flop sync of straps, link pins and commit toggle
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 8'h00;
      pin_s <= 8'h00;
      bclk_prev <= 1'b0;
      sync_fill <= 3'h0;
    end
    else
    begin
      pin_meta <= {req_tgl, word_clock_in, channel_select_clock_in, bit_clock_in,
        edge_polarity_select, first_bit_delay_n, justify_select, slave_select};
      pin_s <= pin_meta;
      bclk_prev <= bclk_s;
      // reset values of the sync stages are not pin levels: wait them out
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  // bit clock events: divided in master, detected from pin in slave
  always_comb
  begin
    if (!sync_ok)
    begin
      // straps and pins still in the synchroniser: no edges, no false start
      tx_ev = 1'b0;
      smp_ev = 1'b0;
    end
    else if (strap.slave)
    begin
      tx_ev = (bclk_s != bclk_prev) && (bclk_s == ~edge_sel);
      smp_ev = (bclk_s != bclk_prev) && (bclk_s == edge_sel);
    end
    else
    begin
      tx_ev = (mdiv == `SSO_DIV_XMIT);
      smp_ev = (mdiv == `SSO_DIV_SAMPLE);
    end
  end

  // frame position after this transmit edge
  always_comb
  begin
    if (!strap.slave)
      next_cnt = cnt + 6'h01;
    // channel pin moves with the transmit edge: field starts at that edge
    else if (lr_s != lr_fld)
      next_cnt = {~lr_s, 5'h00};
    else if (cnt[4:0] != `SSO_FIELD_LAST)
      next_cnt = cnt + 6'h01;
    else
      next_cnt = cnt;
  end

  // divider, frame counter, channel tracking
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdiv <= 2'h0;
      cnt <= `SSO_CNT_RST;
      lr_fld <= 1'b0;
    end
    else
    begin
      mdiv <= mdiv + 2'h1;
      if (tx_ev)
      begin
        cnt <= next_cnt;
        lr_fld <= lr_s;
      end
    end
  end

  // slave waits for channel clock low then high; master runs at once
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
      arm <= sso_pkg::SSO_ARM_LOW;
    else if (!sync_ok)
      arm <= sso_pkg::SSO_ARM_LOW;
    else if (!strap.slave)
      arm <= sso_pkg::SSO_RUN;
    else if (smp_ev)
    begin
      case (arm)
        sso_pkg::SSO_ARM_LOW: if (!lr_s) arm <= sso_pkg::SSO_ARM_HIGH;
        sso_pkg::SSO_ARM_HIGH: if (lr_s) arm <= sso_pkg::SSO_RUN;
        sso_pkg::SSO_RUN: arm <= sso_pkg::SSO_RUN;
        default: arm <= sso_pkg::SSO_ARM_LOW;
      endcase
    end
  end

  // msb slot and word clock shape for each strap setting
  always_comb
  begin
    case ({strap.justify, strap.delay_n})
      2'b11:
      begin
        start_pos = `SSO_POS_RIGHT_JUST;
        next_wclk = (next_cnt[4:0] >= `SSO_POS_RIGHT_JUST);
      end
      2'b10:
      begin
        start_pos = `SSO_POS_RIGHT_JUST_P1;
        next_wclk = (next_cnt[4:0] == `SSO_POS_RIGHT_JUST);
      end
      2'b01:
      begin
        start_pos = `SSO_POS_LEFT_JUST;
        next_wclk = (next_cnt[4:0] < `SSO_POS_RIGHT_JUST);
      end
      default:
      begin
        start_pos = `SSO_POS_I2S;
        next_wclk = (next_cnt[4:0] >= `SSO_POS_I2S) && (next_cnt[4:0] <= `SSO_POS_I2S_END);
      end
    endcase
    if (wc_mode)
      start = wc_pend;
    else
      start = (next_cnt[4:0] == start_pos);
    load_word = next_cnt[5] ? act_pair.right : act_pair.left;
  end

  // word clock input: one start per field after it samples high
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wc_pend <= 1'b0;
      wc_done <= 1'b0;
    end
    else if (tx_ev)
    begin
      wc_pend <= 1'b0;
      if (start)
        wc_done <= 1'b1;
      else if (next_cnt[4:0] == 5'h00 && cnt[4:0] != 5'h00)
        wc_done <= 1'b0;
    end
    else if (smp_ev && wc_mode && wclk_s && !wc_done)
      wc_pend <= 1'b1;
  end

  // shifter: load at msb slot, then one bit per transmitting edge
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg <= 16'h0000;
      bits_left <= 5'h00;
      serial_data_out <= 1'b0;
    end
    else if (tx_ev && active)
    begin
      if (start)
      begin
        serial_data_out <= load_word[15];
        shreg <= {load_word[14:0], 1'b0};
        bits_left <= `SSO_WORD_LAST;
      end
      else if (bits_left != 5'h00)
      begin
        serial_data_out <= shreg[15];
        shreg <= {shreg[14:0], 1'b0};
        bits_left <= bits_left - 5'h01;
      end
      else
        serial_data_out <= 1'b0;
    end
  end

  // commit hand-over from ref side, then refresh in last eighth of frame
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_tgl <= 1'b0;
      pend_pair <= '0;
      act_pair <= '0;
    end
    else
    begin
      if (req_s != ack_tgl)
      begin
        pend_pair <= xfer_pair;
        ack_tgl <= req_s;
      end
      if (tx_ev && active && next_cnt == `SSO_UPDATE_SLOT)
        act_pair <= pend_pair;
    end
  end

  // pin drivers: clocks driven only in master, word clock unless input
  always_ff @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_clock_out <= 1'b0;
      channel_select_clock_out <= 1'b0;
      word_clock_out <= 1'b0;
      bit_clock_oe_n <= 1'b1;
      channel_select_clock_oe_n <= 1'b1;
      word_clock_oe_n <= 1'b1;
    end
    else
    begin
      // stay released until the straps are known
      bit_clock_oe_n <= strap.slave | ~sync_ok;
      channel_select_clock_oe_n <= strap.slave | ~sync_ok;
      word_clock_oe_n <= wc_mode | ~sync_ok;
      if (!strap.slave && tx_ev)
        bit_clock_out <= ~edge_sel;
      else if (!strap.slave && smp_ev)
        bit_clock_out <= edge_sel;
      if (tx_ev && !strap.slave)
        channel_select_clock_out <= ~next_cnt[5];
      if (tx_ev)
        word_clock_out <= active & ~wc_mode & next_wclk;
    end
  end

  // link-side checks
  shift_order_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (tx_ev && active && !start && bits_left != 5'h00)
    |=> (serial_data_out == $past(shreg[15]))) else $error("bit not msb first");
  frame_halves_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (!strap.slave && tx_ev && next_cnt[4:0] == 5'h00)
    |=> (channel_select_clock_out == ~cnt[5])) else $error("channel clock wrong");
  pin_dir_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    $changed(strap.slave) |=> (bit_clock_oe_n == strap.slave)
    && (channel_select_clock_oe_n == strap.slave)) else $error("pin direction wrong");
  rj_frame_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (tx_ev && active && strap.justify && strap.delay_n && next_cnt[4:0] == 5'h10)
    |=> word_clock_out && bits_left == 5'h0F) else $error("right-justify frame late");
  rj1_pulse_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (!strap.slave && strap.justify && !strap.delay_n && tx_ev && next_cnt[4:0] == 5'h10)
    |=> word_clock_out [*4] ##1 !word_clock_out) else $error("word pulse not one bit");
  i2s_slot_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (tx_ev && active && !strap.justify && !strap.delay_n && next_cnt[4:0] == 5'h01)
    |=> (bits_left == 5'h0F) && word_clock_out) else $error("i2s msb slot wrong");
  lj_wclk_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (tx_ev && active && !strap.justify && strap.delay_n && next_cnt[4:0] == 5'h00)
    |=> word_clock_out && bits_left == 5'h0F) else $error("left-justify start wrong");
  bclk_edge_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (!strap.slave && tx_ev && $stable(edge_sel))
    |=> (bit_clock_out == ~edge_sel) ##2 (bit_clock_out == edge_sel))
    else $error("bit clock edge wrong");
  sample_swap_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (tx_ev && active && next_cnt == 6'h38) |=> (act_pair == $past(pend_pair)))
    else $error("sample not refreshed");
  wc_input_a: assert property (@(posedge master_clock_in) disable iff (!rst_n)
    (smp_ev && active && wc_mode && wclk_s && !wc_done && !tx_ev)
    |=> wc_pend) else $error("word clock input missed");

endmodule

// ==== tb/sso_rx_model.sv ====
// serial audio receiver model: makes slave clocks and captures each field
`timescale 1ns/100ps
module sso_rx_model (
  input wire logic master_clock_in,
  input wire logic rst_n,
  input wire logic slave,
  input wire logic edge_sel,
  input wire logic word_in_mode,
  input wire logic bck,
  input wire logic ch,
  input wire logic wck,
  input wire logic sd,
  output logic bck_drv,
  output logic ch_drv,
  output logic wck_drv,
  output int fld_seq,
  output int fld_len,
  output logic fld_left,
  output logic [31:0] fld_data,
  output logic [31:0] fld_wck
);
  int div; // master clocks within one bit period
  int f; // field index of the next sampling edge
  logic [5:0] bit_idx; // bit position within the frame
  logic last_ch; // channel level at the previous sampling edge
  logic [31:0] cur_d; // data bits of the running field
  logic [31:0] cur_w; // word clock bits of the running field
  // clock maker: bit period 8 master clocks, channel flips every 32 bits
  always @(posedge master_clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= 0;
      bit_idx <= 6'h00;
      bck_drv <= edge_sel;
      ch_drv <= 1'b0;
      wck_drv <= 1'b0;
    end
    else if (!slave)
    begin
      // lines belong to the device: show a changing pattern
      bck_drv <= ~bck_drv;
      ch_drv <= ~ch_drv;
      wck_drv <= ~wck_drv;
    end
    else
    begin
      // transmit edge, channel change here: same source as master clock
      if (div == 0)
      begin
        bck_drv <= ~edge_sel;
        ch_drv <= bit_idx[5];
        bit_idx <= bit_idx + 6'h01;
      end
      // sampling edge half a bit later
      if (div == 4)
      begin
        bck_drv <= edge_sel;
      end
      div <= (div + 1) % 8;
      // word clock tied high in the input mode
      wck_drv <= word_in_mode ? 1'b1 : ~wck_drv;
    end
  end
  // capture at each sampling edge; a channel change closes the field
  always @(bck)
  begin
    if (rst_n === 1'b1 && bck === edge_sel)
    begin
      if (ch !== last_ch)
      begin
        fld_left = last_ch;
        fld_data = cur_d;
        fld_wck = cur_w;
        fld_len = f;
        fld_seq = fld_seq + 1;
        f = 0;
        cur_d = 32'h00000000;
        cur_w = 32'h00000000;
      end
      if (f < 32)
      begin
        cur_d[f] = sd;
        cur_w[f] = wck;
      end
      f = f + 1;
      last_ch = ch;
    end
  end
endmodule

// ==== tb/sso_port_tb.sv ====
// testbench for the stereo serial output port in all sixteen strap settings
`timescale 1ns/100ps
`include "sso_cfg.svh"
module sso_port_tb;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_l, exp_r, ed, ew, fld_data, fld_wck;
  logic master_clock_in, slave_select, justify_select, first_bit_delay_n;
  logic edge_polarity_select, bit_clock_out, bit_clock_oe_n, serial_data_out;
  logic channel_select_clock_out, channel_select_clock_oe_n, word_clock_out;
  logic word_clock_oe_n, bck_drv, ch_drv, wck_drv, fld_left, er, chk_on;
  logic [15:0] wrd, oth; // word of this field, word of the other channel
  int errors, check_count, cycles, start, k, fld_seq, fld_len;
  wire logic bck, ch, wck; // resolved link lines
  assign bck = bit_clock_oe_n ? bck_drv : bit_clock_out;
  assign ch = channel_select_clock_oe_n ? ch_drv : channel_select_clock_out;
  assign wck = word_clock_oe_n ? wck_drv : word_clock_out;
  sso_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clock_in(master_clock_in),
    .slave_select(slave_select), .justify_select(justify_select),
    .first_bit_delay_n(first_bit_delay_n), .edge_polarity_select(edge_polarity_select),
    .bit_clock_in(bck_drv), .bit_clock_out(bit_clock_out),
    .bit_clock_oe_n(bit_clock_oe_n), .channel_select_clock_in(ch_drv),
    .channel_select_clock_out(channel_select_clock_out),
    .channel_select_clock_oe_n(channel_select_clock_oe_n), .word_clock_in(wck_drv),
    .word_clock_out(word_clock_out), .word_clock_oe_n(word_clock_oe_n),
    .serial_data_out(serial_data_out));
  sso_rx_model i_rx (.master_clock_in(master_clock_in), .rst_n(rst_n),
    .slave(slave_select), .edge_sel(edge_polarity_select),
    .word_in_mode(slave_select & justify_select & ~first_bit_delay_n), .bck(bck),
    .ch(ch), .wck(wck), .sd(serial_data_out), .bck_drv(bck_drv), .ch_drv(ch_drv),
    .wck_drv(wck_drv), .fld_seq(fld_seq), .fld_len(fld_len), .fld_left(fld_left),
    .fld_data(fld_data), .fld_wck(fld_wck));
  // clocks: register 40 ns, link 48 ns with a phase offset
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    master_clock_in = 1'b0;
    #7;
    forever #24 master_clock_in = ~master_clock_in;
  end
  // compare and count
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      check_count++;
      if (got !== exp)
      begin
        errors++;
        $display("wrong value %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // one apb transfer, called just after a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // pready ends this wait; the hang guard catches a missing one
      while (pready !== 1'b1)
        @(posedge ref_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // verdict and end of run
  task close_out;
    begin
      if (errors == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      close_out;
    end
  end
  // model of one field: word in its slot, zero elsewhere, spill for the +1 mode
  always @(fld_seq)
  begin
    if (chk_on)
    begin
      wrd = fld_left ? exp_l[15:0] : exp_r[15:0];
      oth = fld_left ? exp_r[15:0] : exp_l[15:0];
      for (int f = 0; f < 32; f++)
      begin
        k = f - start;
        ed[f] = (k >= 0 && k < 16) ? wrd[15 - k] : (start == 17 && f == 0 && oth[0]);
        ew[f] = (start == 17) ? (f == 16) : (k >= 0 && k < 16);
      end
      chk("serial data", ed, fld_data);
      if (word_clock_oe_n === 1'b0)
        chk("word clock", ew, fld_wck);
      if (slave_select === 1'b0)
        chk("field length", 32, fld_len);
    end
  end
  // sequence: every strap setting, fresh reset and random pair each
  initial
  begin
    {rst_n, psel, penable, pwrite, chk_on} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {slave_select, justify_select, first_bit_delay_n, edge_polarity_select} = 4'h0;
    void'($urandom(32'hEA4A));
    for (int m = 0; m < 16; m++)
    begin
      rst_n <= 1'b0;
      @(posedge ref_clk);
      {slave_select, justify_select, first_bit_delay_n, edge_polarity_select} <= m[3:0];
      repeat (8) @(posedge ref_clk);
      chk("reset outputs", 32'hE, {bit_clock_oe_n, channel_select_clock_oe_n,
        word_clock_oe_n, serial_data_out});
      rst_n <= 1'b1;
      start = !justify_select ? (first_bit_delay_n ? 0 : 1) :
        (first_bit_delay_n ? 16 : (slave_select ? 1 : 17));
      exp_l = $urandom & 32'h0000FFFF;
      exp_r = $urandom & 32'h0000FFFF;
      @(posedge ref_clk);
      apb(1'b1, `SSO_OFS_LEFT, exp_l);
      apb(1'b1, `SSO_OFS_RIGHT, exp_r);
      apb(1'b0, `SSO_OFS_STATUS, 32'h00000000);
      chk("strap status", {m[1], m[2], m[3]}, rd[4:2]);
      chk("pin directions", {m[3], m[3], m[3] & m[2] & ~m[1]}, {bit_clock_oe_n,
        channel_select_clock_oe_n, word_clock_oe_n});
      repeat (8) @(fld_seq);
      chk_on = 1'b1;
      repeat (4) @(fld_seq);
      chk_on = 1'b0;
    end
    @(posedge ref_clk);
    apb(1'b0, `SSO_OFS_LEFT, 32'h00000000);
    chk("left readback", exp_l, rd);
    // second commit lands while the first hand-over is still open
    apb(1'b1, `SSO_OFS_RIGHT, exp_l);
    apb(1'b1, `SSO_OFS_RIGHT, exp_r);
    apb(1'b0, `SSO_OFS_STATUS, 32'h00000000);
    chk("overrun set", 32'h1, rd[1]);
    apb(1'b1, `SSO_OFS_STATUS, 32'h00000002);
    apb(1'b0, `SSO_OFS_STATUS, 32'h00000000);
    chk("overrun clear", 32'h0, rd[1]);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk("unmapped read", 32'h00000000, rd);
    chk("unmapped error", 32'h1, er);
    close_out;
  end
endmodule
